// file: src/ers_status.sv
// Purpose: receive sync/timer status bank, page 03H addresses 10H-1FH
// Assumes: framer inputs on mclk; processor port pins asynchronous
// Notes:   read-only bank; data_in accepted for pin symmetry but never stored
`timescale 1ns/1ps

module ers_status #(
  parameter int unsigned MS_CYCLES = ers_pkg::MS_CYC
) (
  input  wire logic                mclk,
  input  wire logic                resetn,
  input  wire ers_pkg::ers_framer_s framer,
  input  wire ers_pkg::ers_ext_s    ext,
  input  wire logic                free_run,
  input  wire logic                maintenance_option,
  input  wire logic                auto_interworking,
  input  wire logic                page_is_status,
  input  wire logic                cs_n,
  input  wire logic                rd_n,
  input  wire logic [4:0]          addr,
  input  wire logic [7:0]          data_in,
  output logic [7:0]               data_out,
  output logic                     data_oe,
  output logic                     crc_reframe_request
);

  // ---------------- processor port synchronisers ----------------
  logic [6:0] pin_meta;
  logic [6:0] pin_sync;
  logic       rd_active;
  logic [7:0] read_value;
  logic [7:0] next_data_out;
  logic       next_data_oe;

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      pin_meta <= 7'h7f;
      pin_sync <= 7'h7f;
    end else begin
      pin_meta <= {cs_n, rd_n, addr};
      pin_sync <= pin_meta;
    end
  end

  assign rd_active = !pin_sync[6] && !pin_sync[5] && page_is_status;

  // ---------------- status state ----------------
  logic [17:0] ms_cnt;
  logic [17:0] next_ms_cnt;
  logic        ms_tick;
  logic [8:0]  half_cnt;
  logic [8:0]  next_half_cnt;
  logic [8:0]  red_cnt;
  logic [8:0]  next_red_cnt;
  logic [8:0]  tl_cnt;
  logic [8:0]  next_tl_cnt;
  logic [8:0]  ta_cnt;
  logic [8:0]  next_ta_cnt;
  logic [8:0]  align_cnt;
  logic [8:0]  next_align_cnt;
  logic [8:0]  ka_cnt;
  logic [8:0]  next_ka_cnt;
  logic        align_run;
  logic        next_align_run;
  logic        frame_loss_q;
  logic        next_frame_loss_q;

  logic        rx_e_bit_one;
  logic        next_rx_e_bit_one;
  logic        rx_e_bit_two;
  logic        next_rx_e_bit_two;
  logic        crc_reframe_flag;
  logic        next_crc_reframe_flag;
  logic        frame_loss_alarm;
  logic        next_frame_loss_alarm;
  logic        crc_interworking_flag;
  logic        next_crc_interworking_flag;
  logic [7:0]  rx_fas;
  logic [7:0]  next_rx_fas;
  logic        half_second_toggle;
  logic        next_half_second_toggle;
  logic        one_second_toggle;
  logic        next_one_second_toggle;
  logic        terminal_loss_timer;
  logic        next_terminal_loss_timer;
  logic        terminal_acquire_timer;
  logic        next_terminal_acquire_timer;
  logic        long_align_timer_toggle;
  logic        next_long_align_timer_toggle;
  logic        short_align_timer_toggle;
  logic        next_short_align_timer_toggle;
  logic        crc_align_tick;
  logic        next_crc_align_tick;
  logic        keep_alive_flag;
  logic        next_keep_alive_flag;
  logic        next_reframe_req;

  logic [7:0]  sync_status_word;
  logic [7:0]  timer_status_word;

  always_comb begin
    next_ms_cnt = ms_cnt + 18'h0_0001;
    ms_tick     = 1'b0;
    if (ms_cnt == 18'(MS_CYCLES - 1)) begin
      next_ms_cnt = 18'h0_0000;
      ms_tick     = 1'b1;
    end
    // once aligned, ms phase follows the far-end CRC-4 sync
    if (!framer.crc_multiframe_loss && framer.crc_sync_pulse) begin
      next_ms_cnt = 18'h0_0000;
      ms_tick     = 1'b1;
    end
    next_crc_align_tick = crc_align_tick ^ ms_tick;

    next_rx_e_bit_one = rx_e_bit_one;
    next_rx_e_bit_two = rx_e_bit_two;
    if (framer.crc_mf_strobe) begin
      next_rx_e_bit_one = framer.e_bit_one;
      next_rx_e_bit_two = framer.e_bit_two;
    end

    next_rx_fas = rx_fas;
    if (framer.fas_strobe) begin
      next_rx_fas = framer.fas_byte;
    end

    // red alarm: continuous loss for 100 ms
    next_red_cnt          = red_cnt;
    next_frame_loss_alarm = frame_loss_alarm;
    if (!framer.frame_loss) begin
      next_red_cnt          = 9'h000;
      next_frame_loss_alarm = 1'b0;
    end else if (ms_tick && !frame_loss_alarm) begin
      next_red_cnt = red_cnt + 9'h001;
      if (red_cnt == 9'(ers_pkg::RED_MS - 1)) begin
        next_frame_loss_alarm = 1'b1;
      end
    end

    // keep-alive: AIS held 100 ms
    next_ka_cnt          = ka_cnt;
    next_keep_alive_flag = keep_alive_flag;
    if (!framer.ais_status) begin
      next_ka_cnt          = 9'h000;
      next_keep_alive_flag = 1'b0;
    end else if (ms_tick && !keep_alive_flag) begin
      next_ka_cnt = ka_cnt + 9'h001;
      if (ka_cnt == 9'(ers_pkg::KEEP_ALIVE_MS - 1)) begin
        next_keep_alive_flag = 1'b1;
      end
    end

    // second toggles, frozen in free-run
    next_half_cnt           = half_cnt;
    next_half_second_toggle = half_second_toggle;
    next_one_second_toggle  = one_second_toggle;
    if (free_run) begin
      next_half_cnt = 9'h000;
    end else if (ms_tick) begin
      next_half_cnt = half_cnt + 9'h001;
      if (half_cnt == 9'(ers_pkg::HALF_SEC_MS - 1)) begin
        next_half_cnt           = 9'h000;
        next_half_second_toggle = !half_second_toggle;
        // every second half-second edge
        if (half_second_toggle) begin
          next_one_second_toggle = !one_second_toggle;
        end
      end
    end

    // terminal timers, idle and low in free-run
    next_tl_cnt                 = tl_cnt;
    next_ta_cnt                 = ta_cnt;
    next_terminal_loss_timer    = terminal_loss_timer;
    next_terminal_acquire_timer = terminal_acquire_timer;
    if (free_run) begin
      next_tl_cnt                 = 9'h000;
      next_ta_cnt                 = 9'h000;
      next_terminal_loss_timer    = 1'b0;
      next_terminal_acquire_timer = 1'b0;
    end else begin
      if (!framer.frame_loss) begin
        next_tl_cnt = 9'h000;
      end else if (ms_tick && tl_cnt != 9'(ers_pkg::TERM_LOSS_MS)) begin
        next_tl_cnt = tl_cnt + 9'h001;
        if (tl_cnt == 9'(ers_pkg::TERM_LOSS_MS - 1)) begin
          next_terminal_loss_timer = 1'b1;
        end
      end
      if (framer.frame_loss || !framer.normal_frames) begin
        next_ta_cnt                 = 9'h000;
        next_terminal_acquire_timer = 1'b0;
      end else if (ms_tick && !terminal_acquire_timer) begin
        next_ta_cnt = ta_cnt + 9'h001;
        if (ta_cnt == 9'(ers_pkg::TERM_ACQ_MS - 1)) begin
          next_terminal_acquire_timer = 1'b1;
        end
      end
      // acquire rising wins over a pending loss
      if (next_terminal_acquire_timer && !terminal_acquire_timer) begin
        next_terminal_loss_timer = 1'b0;
      end
    end

    // CRC-4 alignment timers start at basic frame sync
    next_frame_loss_q             = framer.frame_loss;
    next_align_run                = align_run;
    next_align_cnt                = align_cnt;
    next_crc_reframe_flag         = crc_reframe_flag;
    next_crc_interworking_flag    = crc_interworking_flag;
    next_long_align_timer_toggle  = long_align_timer_toggle;
    next_short_align_timer_toggle = short_align_timer_toggle;
    next_reframe_req              = 1'b0;
    if (framer.frame_loss) begin
      next_align_run        = 1'b0;
      next_align_cnt        = 9'h000;
      next_crc_reframe_flag = 1'b0;
    end else if (frame_loss_q) begin
      next_align_run = 1'b1;
      next_align_cnt = 9'h000;
    end else if (!framer.crc_multiframe_loss) begin
      next_align_run             = 1'b0;
      next_crc_reframe_flag      = 1'b0;
      next_crc_interworking_flag = 1'b1;
    end else if (align_run && ms_tick) begin
      next_align_cnt = align_cnt + 9'h001;
      if (align_cnt == 9'(ers_pkg::SHORT_ALIGN_MS - 1)) begin
        next_short_align_timer_toggle = !short_align_timer_toggle;
        next_crc_reframe_flag         = 1'b1;
        next_reframe_req              = maintenance_option && !auto_interworking;
      end
      if (align_cnt == 9'(ers_pkg::LONG_ALIGN_MS - 1)) begin
        next_long_align_timer_toggle = !long_align_timer_toggle;
        next_crc_interworking_flag   = 1'b0;
        next_align_run               = 1'b0;
      end
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      ms_cnt                   <= 18'h0_0000;
      half_cnt                 <= 9'h000;
      red_cnt                  <= 9'h000;
      tl_cnt                   <= 9'h000;
      ta_cnt                   <= 9'h000;
      align_cnt                <= 9'h000;
      ka_cnt                   <= 9'h000;
      align_run                <= 1'b0;
      frame_loss_q             <= 1'b1;
      rx_e_bit_one             <= 1'b0;
      rx_e_bit_two             <= 1'b0;
      crc_reframe_flag         <= 1'b0;
      frame_loss_alarm         <= 1'b0;
      crc_interworking_flag    <= 1'b0;
      rx_fas                   <= ers_pkg::FAS_RESET;
      half_second_toggle       <= 1'b0;
      one_second_toggle        <= 1'b0;
      terminal_loss_timer      <= 1'b0;
      terminal_acquire_timer   <= 1'b0;
      long_align_timer_toggle  <= 1'b0;
      short_align_timer_toggle <= 1'b0;
      crc_align_tick           <= 1'b0;
      keep_alive_flag          <= 1'b0;
      crc_reframe_request      <= 1'b0;
    end else begin
      ms_cnt                   <= next_ms_cnt;
      half_cnt                 <= next_half_cnt;
      red_cnt                  <= next_red_cnt;
      tl_cnt                   <= next_tl_cnt;
      ta_cnt                   <= next_ta_cnt;
      align_cnt                <= next_align_cnt;
      ka_cnt                   <= next_ka_cnt;
      align_run                <= next_align_run;
      frame_loss_q             <= next_frame_loss_q;
      rx_e_bit_one             <= next_rx_e_bit_one;
      rx_e_bit_two             <= next_rx_e_bit_two;
      crc_reframe_flag         <= next_crc_reframe_flag;
      frame_loss_alarm         <= next_frame_loss_alarm;
      crc_interworking_flag    <= next_crc_interworking_flag;
      rx_fas                   <= next_rx_fas;
      half_second_toggle       <= next_half_second_toggle;
      one_second_toggle        <= next_one_second_toggle;
      terminal_loss_timer      <= next_terminal_loss_timer;
      terminal_acquire_timer   <= next_terminal_acquire_timer;
      long_align_timer_toggle  <= next_long_align_timer_toggle;
      short_align_timer_toggle <= next_short_align_timer_toggle;
      crc_align_tick           <= next_crc_align_tick;
      keep_alive_flag          <= next_keep_alive_flag;
      crc_reframe_request      <= next_reframe_req;
    end
  end

  // live loss levels, no extra latency
  assign sync_status_word = {framer.frame_loss,
                             framer.signalling_multiframe_loss,
                             framer.crc_multiframe_loss,
                             rx_e_bit_one, rx_e_bit_two,
                             crc_reframe_flag, frame_loss_alarm, crc_interworking_flag};
  assign timer_status_word = {half_second_toggle, one_second_toggle,
                              terminal_loss_timer, terminal_acquire_timer,
                              long_align_timer_toggle, short_align_timer_toggle,
                              crc_align_tick, keep_alive_flag};

  // ---------------- read decode ----------------
  always_comb begin
    if (pin_sync[4:0] == ers_pkg::ADDR_SYNC_STATUS) begin
      read_value = sync_status_word;
    end else if (pin_sync[4:0] == ers_pkg::ADDR_RX_FAS) begin
      read_value = rx_fas;
    end else if (pin_sync[4:0] == ers_pkg::ADDR_TIMER) begin
      read_value = timer_status_word;
    end else if (pin_sync[4:0] == ers_pkg::ADDR_NFAS) begin
      read_value = ext.rx_non_frame_align_signal;
    end else if (pin_sync[4:0] == ers_pkg::ADDR_MFAS) begin
      read_value = ext.rx_multiframe_align_signal;
    end else if (pin_sync[4:0] == ers_pkg::ADDR_PHASE_HI) begin
      read_value = ext.phase_status_high;
    end else if (pin_sync[4:0] == ers_pkg::ADDR_PHASE_LO) begin
      read_value = ext.phase_status_low;
    end else if (pin_sync[4:0] == ers_pkg::ADDR_JITTER) begin
      read_value = ext.jitter_buffer_status;
    end else if (pin_sync[4:0] == ers_pkg::ADDR_LINE_LEVEL) begin
      read_value = ext.rx_line_level_status;
    end else if (pin_sync[4:0] == ers_pkg::ADDR_ALARM_ONE) begin
      read_value = ext.alarm_status_one;
    end else if (pin_sync[4:0] == ers_pkg::ADDR_SPARE_CHG) begin
      read_value = ext.spare_bit_change_report;
    end else if (pin_sync[4:0] == ers_pkg::ADDR_IDENT) begin
      read_value = ers_pkg::CHIP_ID_DEFAULT;
    end else begin
      read_value = ers_pkg::DATA_RESET;
    end
    // writes never reach any register here; data_in is left unstored
    next_data_oe  = rd_active;
    next_data_out = rd_active ? read_value : ers_pkg::DATA_RESET;
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      data_out <= ers_pkg::DATA_RESET;
      data_oe  <= 1'b0;
    end else begin
      data_out <= next_data_out;
      data_oe  <= next_data_oe;
    end
  end

endmodule

// file: include/ers_pkg.sv
// Purpose: constants and carriers for the receive sync/timer status bank
// Assumes: 200 MHz mclk, status page selected by upstream page logic
// Notes:   timer limits are in milliseconds, counted on a shared ms tick
package ers_pkg;
  localparam int unsigned CLK_PERIOD_PS  = 5_000;
  localparam int unsigned MS_PS          = 1_000_000_000;
  localparam int unsigned MS_CYC         = MS_PS / CLK_PERIOD_PS;

  localparam int unsigned HALF_SEC_MS    = 500;
  localparam int unsigned RED_MS         = 100;
  localparam int unsigned TERM_LOSS_MS   = 100;
  localparam int unsigned TERM_ACQ_MS    = 10;
  localparam int unsigned LONG_ALIGN_MS  = 400;
  localparam int unsigned SHORT_ALIGN_MS = 8;
  localparam int unsigned KEEP_ALIVE_MS  = 100;

  localparam logic [4:0] ADDR_SYNC_STATUS = 5'h10;
  localparam logic [4:0] ADDR_RX_FAS      = 5'h11;
  localparam logic [4:0] ADDR_TIMER       = 5'h12;
  localparam logic [4:0] ADDR_NFAS        = 5'h13;
  localparam logic [4:0] ADDR_MFAS        = 5'h14;
  localparam logic [4:0] ADDR_PHASE_HI    = 5'h15;
  localparam logic [4:0] ADDR_PHASE_LO    = 5'h16;
  localparam logic [4:0] ADDR_JITTER      = 5'h17;
  localparam logic [4:0] ADDR_LINE_LEVEL  = 5'h18;
  localparam logic [4:0] ADDR_ALARM_ONE   = 5'h19;
  localparam logic [4:0] ADDR_SPARE_CHG   = 5'h1a;
  localparam logic [4:0] ADDR_IDENT       = 5'h1f;

  // arbitrary neutral identity value
  localparam logic [7:0] CHIP_ID_DEFAULT  = 8'h5c;

  localparam logic [7:0] FAS_RESET        = 8'h00;
  localparam logic [7:0] DATA_RESET       = 8'h00;

  // framer status, all on mclk
  typedef struct packed {
    logic       frame_loss;
    logic       signalling_multiframe_loss;
    logic       crc_multiframe_loss;
    logic       crc_mf_strobe;
    logic       e_bit_one;
    logic       e_bit_two;
    logic       fas_strobe;
    logic [7:0] fas_byte;
    logic       crc_sync_pulse;
    logic       normal_frames;
    logic       ais_status;
  } ers_framer_s;

  // registers kept elsewhere, presented for readback
  typedef struct packed {
    logic [7:0] rx_non_frame_align_signal;
    logic [7:0] rx_multiframe_align_signal;
    logic [7:0] phase_status_high;
    logic [7:0] phase_status_low;
    logic [7:0] jitter_buffer_status;
    logic [7:0] rx_line_level_status;
    logic [7:0] alarm_status_one;
    logic [7:0] spare_bit_change_report;
  } ers_ext_s;
endpackage

// file: dv/ers_status_checker.sv
// Purpose: port-level assertions for the receive status bank
// Assumes: read path is 2 sync flops plus 1 output register
// Notes:   strobes held 4 cycles so address and page settle first
`timescale 1ns/1ps

module ers_status_checker #(
  parameter int unsigned MS_CYCLES = ers_pkg::MS_CYC
) (
  input wire logic                 mclk,
  input wire logic                 resetn,
  input wire ers_pkg::ers_framer_s framer,
  input wire ers_pkg::ers_ext_s    ext,
  input wire logic                 free_run,
  input wire logic                 maintenance_option,
  input wire logic                 auto_interworking,
  input wire logic                 page_is_status,
  input wire logic                 cs_n,
  input wire logic                 rd_n,
  input wire logic [4:0]           addr,
  input wire logic [7:0]           data_in,
  input wire logic [7:0]           data_out,
  input wire logic                 data_oe,
  input wire logic                 crc_reframe_request
);
  logic rd_now;
  assign rd_now = !cs_n && !rd_n && page_is_status;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);

  property p_oe_rise; rd_now[*4] |-> data_oe; endproperty
  a_oe_rise: assert property (p_oe_rise) else $error("read held but bus not driven");
  property p_idle; cs_n |-> ##3 (!data_oe && data_out == 8'h00); endproperty
  a_idle: assert property (p_idle) else $error("bus driven without a read");
  property p_no_page; (!page_is_status)[*4] |-> !data_oe; endproperty
  a_no_page: assert property (p_no_page) else $error("bus driven off the status page");
  property p_unused; (rd_now && addr >= 5'h1b && addr <= 5'h1e)[*4] |-> data_out == 8'h00; endproperty
  a_unused: assert property (p_unused) else $error("unused address not zero");
  property p_ident; (rd_now && addr == ers_pkg::ADDR_IDENT)[*4] |-> data_out == ers_pkg::CHIP_ID_DEFAULT; endproperty
  a_ident: assert property (p_ident) else $error("identity readback wrong");
  property p_ext; (rd_now && addr == ers_pkg::ADDR_NFAS)[*4] |-> data_out == ext.rx_non_frame_align_signal; endproperty
  a_ext: assert property (p_ext) else $error("external register readback wrong");
  // live bit seen through one output register, so demand two stable samples
  property p_live;
    (rd_now && addr == ers_pkg::ADDR_SYNC_STATUS)[*4] ##0 (framer.frame_loss == $past(framer.frame_loss)
      && framer.frame_loss == $past(framer.frame_loss, 2)) |-> data_out[7] == framer.frame_loss;
  endproperty
  a_live: assert property (p_live) else $error("frame loss bit wrong");
  property p_pulse; crc_reframe_request |=> !crc_reframe_request; endproperty
  a_pulse: assert property (p_pulse) else $error("reframe request longer than one cycle");
  property p_cause; crc_reframe_request |-> $past(maintenance_option) && !$past(auto_interworking); endproperty
  a_cause: assert property (p_cause) else $error("reframe forced with wrong options");
endmodule

bind ers_status ers_status_checker #(.MS_CYCLES(MS_CYCLES)) u_chk (
  .mclk(mclk), .resetn(resetn), .framer(framer), .ext(ext), .free_run(free_run),
  .maintenance_option(maintenance_option), .auto_interworking(auto_interworking),
  .page_is_status(page_is_status), .cs_n(cs_n), .rd_n(rd_n), .addr(addr), .data_in(data_in),
  .data_out(data_out), .data_oe(data_oe), .crc_reframe_request(crc_reframe_request));

// file: dv/ers_line_model.sv
// Purpose: far-side framer stand-in feeding the status bank
// Assumes: tasks called from the bench at falling edges
// Notes:   data fields scrambled outside strobes so stale values never pass
`timescale 1ns/1ps

module ers_line_model (
  input  wire logic            mclk,
  output ers_pkg::ers_framer_s framer
);
  initial begin
    framer = '0;
    framer.frame_loss = 1'b1;
    framer.signalling_multiframe_loss = 1'b1;
    framer.crc_multiframe_loss = 1'b1;
    framer.ais_status = 1'b1;
  end

  task automatic set_levels(input logic fl, input logic sm, input logic cm, input logic nf, input logic ais);
    @(negedge mclk);
    framer.frame_loss = fl;
    framer.signalling_multiframe_loss = sm;
    framer.crc_multiframe_loss = cm;
    framer.normal_frames = nf;
    framer.ais_status = ais;
  endtask

  task automatic send_fas(input logic [7:0] b);
    @(negedge mclk);
    framer.fas_byte = b;
    framer.fas_strobe = 1'b1;
    @(negedge mclk);
    framer.fas_strobe = 1'b0;
    framer.fas_byte = ~b;
  endtask

  // one-cycle receive CRC-4 sync pulse
  task automatic send_sync();
    @(negedge mclk);
    framer.crc_sync_pulse = 1'b1;
    @(negedge mclk);
    framer.crc_sync_pulse = 1'b0;
  endtask

  task automatic send_mf(input logic e1, input logic e2);
    @(negedge mclk);
    framer.e_bit_one = e1;
    framer.e_bit_two = e2;
    framer.crc_mf_strobe = 1'b1;
    @(negedge mclk);
    framer.crc_mf_strobe = 1'b0;
    framer.e_bit_one = ~e1;
    framer.e_bit_two = ~e2;
  endtask
endmodule

// file: dv/ers_status_bench.sv
// Purpose: directed bench for the receive status bank
// Assumes: ms tick shortened to 20 cycles
// Notes:   timer checks sample mid-tick to stay clear of phase slop
`timescale 1ns/1ps

module ers_status_bench;
  localparam int unsigned MSC     = 20;
  localparam logic [63:0] EXT_VAL = 64'h3c5a_9612_e187_4bd2;
  logic                mclk;
  logic                resetn;
  logic                free_run;
  logic                maint_opt;
  logic                auto_iw;
  logic                page_is_status;
  logic                cs_n;
  logic                rd_n;
  logic [4:0]          addr;
  logic [7:0]          data_in;
  logic [7:0]          data_out;
  logic [7:0]          d;
  logic                data_oe;
  logic                crc_reframe_request;
  ers_pkg::ers_framer_s framer;
  int                  miscompares;
  int                  n_checks;
  int                  n_req;
  int                  cyc;

  ers_line_model line (.mclk(mclk), .framer(framer));
  ers_status #(.MS_CYCLES(MSC)) uut (
    .mclk(mclk), .resetn(resetn), .framer(framer), .ext(ers_pkg::ers_ext_s'(EXT_VAL)), .free_run(free_run),
    .maintenance_option(maint_opt), .auto_interworking(auto_iw), .page_is_status(page_is_status), .cs_n(cs_n),
    .rd_n(rd_n), .addr(addr), .data_in(data_in), .data_out(data_out), .data_oe(data_oe),
    .crc_reframe_request(crc_reframe_request));

  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end

  always @(posedge mclk or negedge resetn) begin
    if (!resetn) cyc <= 0;
    else cyc <= cyc + 1;
  end
  always @(posedge mclk) begin
    if (crc_reframe_request === 1'b1) n_req++;
  end

  task automatic report_and_stop();
    if (miscompares == 0 && n_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // strobes held 5 cycles: 2 sync flops, output register, two spare
  task automatic access(input logic [4:0] a, input logic rd, output logic [7:0] v);
    cs_n = 1'b0;
    rd_n = rd;
    addr = a;
    data_in = 8'hff;
    repeat (5) @(negedge mclk);
    v = data_out;
    cs_n = 1'b1;
    rd_n = 1'b1;
    repeat (4) @(negedge mclk);
  endtask

  task automatic rdc(input logic [4:0] a, input logic [7:0] mask, input logic [7:0] exp);
    logic [7:0] v;
    access(a, 1'b0, v);
    check(v & mask, exp);
  endtask

  task automatic wait_at(input int c);
    while (cyc < c) @(negedge mclk);
  endtask

  initial begin
    repeat (40000) @(posedge mclk);
    miscompares++;
    report_and_stop();
  end

  initial begin
    resetn = 1'b0;
    free_run = 1'b0;
    maint_opt = 1'b1;
    auto_iw = 1'b0;
    page_is_status = 1'b1;
    cs_n = 1'b1;
    rd_n = 1'b1;
    addr = 5'h00;
    data_in = 8'h00;
    repeat (20) @(negedge mclk);
    resetn = 1'b1;
    rdc(5'h10, 8'hff, 8'he0);
    line.send_fas(8'h1b);
    rdc(5'h11, 8'hff, 8'h1b);
    line.send_fas(8'h9b);
    rdc(5'h11, 8'hff, 8'h9b);
    access(5'h11, 1'b1, d);
    rdc(5'h11, 8'hff, 8'h9b);
    for (int i = 0; i < 8; i++) rdc(5'(5'h13 + i), 8'hff, EXT_VAL[63 - 8 * i -: 8]);
    for (int a = 5'h1b; a <= 5'h1e; a++) rdc(5'(a), 8'hff, 8'h00);
    rdc(ers_pkg::ADDR_IDENT, 8'hff, ers_pkg::CHIP_ID_DEFAULT);
    page_is_status = 1'b0;
    rdc(5'h10, 8'hff, 8'h00);
    page_is_status = 1'b1;
    // two samples 15 cycles apart, one tick between them
    access(5'h12, 1'b0, d);
    repeat (6) @(negedge mclk);
    rdc(5'h12, 8'h02, ~d & 8'h02);
    wait_at(95 * MSC);
    rdc(5'h10, 8'hff, 8'he0);
    rdc(5'h12, 8'hfd, 8'h00);
    wait_at(105 * MSC);
    rdc(5'h10, 8'hff, 8'he2);
    rdc(5'h12, 8'hfd, 8'h21);
    line.set_levels(1'b1, 1'b1, 1'b1, 1'b0, 1'b0);
    rdc(5'h12, 8'h01, 8'h00);
    line.set_levels(1'b0, 1'b1, 1'b1, 1'b1, 1'b0);
    wait_at(114 * MSC + 10);
    rdc(5'h10, 8'hff, 8'h64);
    wait_at(118 * MSC);
    rdc(5'h12, 8'hfd, 8'h14);
    check(8'(n_req), 8'h01);
    line.set_levels(1'b0, 1'b0, 1'b0, 1'b1, 1'b0);
    rdc(5'h10, 8'hff, 8'h01);
    // sync pulse off the free ms phase; a free tick would land between the samples
    wait_at(119 * MSC + 5);
    line.send_sync();
    access(5'h12, 1'b0, d);
    repeat (6) @(negedge mclk);
    rdc(5'h12, 8'h02, d & 8'h02);
    line.send_mf(1'b1, 1'b0);
    rdc(5'h10, 8'hff, 8'h11);
    line.send_mf(1'b0, 1'b1);
    rdc(5'h10, 8'hff, 8'h09);
    line.set_levels(1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
    rdc(5'h12, 8'h10, 8'h00);
    line.set_levels(1'b1, 1'b0, 1'b1, 1'b0, 1'b0);
    line.set_levels(1'b0, 1'b0, 1'b1, 1'b0, 1'b0);
    wait_at(522 * MSC);
    rdc(5'h10, 8'hff, 8'h2c);
    rdc(5'h12, 8'h3c, 8'h08);
    check(8'(n_req), 8'h02);
    // flag still sets, but no forced reframe without the option pair
    auto_iw = 1'b1;
    line.set_levels(1'b1, 1'b0, 1'b1, 1'b0, 1'b0);
    line.set_levels(1'b0, 1'b0, 1'b1, 1'b0, 1'b0);
    wait_at(535 * MSC);
    rdc(5'h10, 8'h04, 8'h04);
    check(8'(n_req), 8'h02);
    auto_iw = 1'b0;
    maint_opt = 1'b0;
    line.set_levels(1'b1, 1'b0, 1'b1, 1'b0, 1'b0);
    line.set_levels(1'b0, 1'b0, 1'b1, 1'b0, 1'b0);
    wait_at(545 * MSC);
    rdc(5'h10, 8'h04, 8'h04);
    check(8'(n_req), 8'h02);
    rdc(5'h12, 8'hc0, 8'h80);
    wait_at(1010 * MSC);
    rdc(5'h12, 8'hc0, 8'h40);
    free_run = 1'b1;
    wait_at(1510 * MSC);
    rdc(5'h12, 8'hf0, 8'h40);
    report_and_stop();
  end
endmodule
